//--- logic/ddc_sync_control.sv
/*
  Sync gating, one-shot handling, oscillator accumulator, half-band phase, output
  mixer phase and the sample path with its output FIFO.
  Assumes sync_i and the register port are synchronous to clock_i.
*/
`timescale 1ns/1ps

// ============================================================
// Sample FIFO
module sample_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW:0] count_reg;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready_o = (count_reg != (PW+1)'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem[rd_ptr_reg];

  // Storage array; no reset so it maps to plain memory.
  always_ff @(posedge clock_i)
  begin
    if (push)
    begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end

  // Pointers wrap naturally because the depth is a power of two.
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

// ============================================================
// Sync and filter control top
module ddc_sync_control (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic sync_i,
  input wire ddc_ctrl_pkg::reg_req_s reg_req_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire ddc_ctrl_pkg::sample_s sample_i,
  input wire logic sample_valid_i,
  output logic sample_ready_o,
  output ddc_ctrl_pkg::sample_s sample_o,
  output logic sample_valid_o,
  input wire logic sample_ready_i,
  output logic clkdiv_sync_o,
  output logic osc_sync_o,
  output logic halfband_sync_o,
  output logic mixer_sync_o,
  output logic monitor_sync_o,
  output logic [31:0] phase_accumulator_32_o,
  output logic osc_enable_o,
  output logic phase_dither_o,
  output logic amp_dither_o,
  output logic halfband_phase_o,
  output logic halfband_highpass_o,
  output logic spectral_reverse_o,
  output logic fir_enable_o,
  output logic [2:0] eighth_rate_mixer_phase_o
);
  import ddc_ctrl_pkg::*;

  logic [7:0] sync_gate_control_reg;
  logic [7:0] output_mix_control_reg;
  logic [7:0] fir_output_mode_control_reg;
  logic [7:0] halfband_filter_control_reg;
  logic [7:0] oscillator_control_reg;
  logic [31:0] osc_freq_reg;
  logic [15:0] osc_phase_reg;
  logic sync_prev_reg;
  logic sync_edge;
  logic master;
  logic pass_clkdiv;
  logic pass_osc;
  logic pass_hb;
  logic pass_mix;
  logic pass_mon;
  logic wr_sync;
  logic wr_mix;
  logic [31:0] acc_reg;
  logic hb_phase_reg;
  logic [2:0] mix_phase_reg;
  sample_s stage_reg;
  sample_s stage_next;
  logic stage_valid_reg;
  logic fifo_ready;
  logic stage_take;

  // A held-high sync input gives only one event. [RQ22]
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sync_prev_reg <= 1'b0;
    end
    else
    begin
      sync_prev_reg <= sync_i;
    end
  end
  assign sync_edge = sync_i && !sync_prev_reg; // [RQ22]

  // Every gate needs the master enable. [RQ1]
  assign master = sync_gate_control_reg[SG_MASTER];
  assign pass_mon = sync_edge && master && sync_gate_control_reg[SG_MON_EN]; // [RQ2]
  assign pass_hb = sync_edge && master && sync_gate_control_reg[SG_HB_EN]; // [RQ3]
  assign pass_osc = sync_edge && master && sync_gate_control_reg[SG_OSC_EN]; // [RQ5]
  assign pass_clkdiv = sync_edge && master && sync_gate_control_reg[SG_CLKDIV_EN]; // [RQ7]
  assign pass_mix = sync_edge && master && output_mix_control_reg[MX_EN]; // [RQ9]
  assign wr_sync = reg_req_i.wr && (reg_req_i.addr == SYNC_GATE_ADDR);
  assign wr_mix = reg_req_i.wr && (reg_req_i.addr == MIX_CTRL_ADDR);

  // Sync gate register; one-shot enables clear on the sync they pass, but a
  // software write in the same cycle wins so a re-arm is never lost.
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sync_gate_control_reg <= REG_RESET;
    end
    else if (wr_sync)
    begin
      sync_gate_control_reg <= reg_req_i.wdata; // [RQ23]
    end
    else
    begin
      if (pass_hb && sync_gate_control_reg[SG_HB_ONCE])
      begin
        sync_gate_control_reg[SG_HB_EN] <= 1'b0; // [RQ4] [RQ23]
      end
      if (pass_osc && sync_gate_control_reg[SG_OSC_ONCE])
      begin
        sync_gate_control_reg[SG_OSC_EN] <= 1'b0; // [RQ6] [RQ23]
      end
      if (pass_clkdiv && sync_gate_control_reg[SG_CLKDIV_ONCE])
      begin
        sync_gate_control_reg[SG_CLKDIV_EN] <= 1'b0; // [RQ8] [RQ23]
      end
    end
  end

  // Mixer control; the one-shot clears the mixer's own enable, not the master.
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      output_mix_control_reg <= REG_RESET;
    end
    else if (wr_mix)
    begin
      output_mix_control_reg <= reg_req_i.wdata & MX_WR_MASK; // [RQ23]
    end
    else if (pass_mix && output_mix_control_reg[MX_ONCE])
    begin
      output_mix_control_reg[MX_EN] <= 1'b0; // [RQ10]
    end
  end

  // Plain configuration registers; reserved bits are never stored.
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      fir_output_mode_control_reg <= REG_RESET;
      halfband_filter_control_reg <= REG_RESET;
      oscillator_control_reg <= REG_RESET;
      osc_freq_reg <= '0;
      osc_phase_reg <= '0;
    end
    else if (reg_req_i.wr)
    begin
      case (reg_req_i.addr)
        FIR_MODE_ADDR: fir_output_mode_control_reg <= reg_req_i.wdata & FM_WR_MASK;
        HB_CTRL_ADDR: halfband_filter_control_reg <= reg_req_i.wdata & HB_WR_MASK;
        OSC_CTRL_ADDR: oscillator_control_reg <= reg_req_i.wdata & OC_WR_MASK;
        OSC_FREQ0_ADDR: osc_freq_reg[7:0] <= reg_req_i.wdata;
        OSC_FREQ1_ADDR: osc_freq_reg[15:8] <= reg_req_i.wdata;
        OSC_FREQ2_ADDR: osc_freq_reg[23:16] <= reg_req_i.wdata;
        OSC_FREQ3_ADDR: osc_freq_reg[31:24] <= reg_req_i.wdata;
        OSC_PHASE0_ADDR: osc_phase_reg[7:0] <= reg_req_i.wdata;
        OSC_PHASE1_ADDR: osc_phase_reg[15:8] <= reg_req_i.wdata;
        default: osc_phase_reg <= osc_phase_reg;
      endcase
    end
  end

  // Read port: registered data one cycle after the request, zero when unmapped.
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      reg_rdata_o <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end
    else
    begin
      reg_rvalid_o <= reg_req_i.rd;
      if (reg_req_i.rd)
      begin
        case (reg_req_i.addr)
          SYNC_GATE_ADDR: reg_rdata_o <= sync_gate_control_reg;
          MIX_CTRL_ADDR: reg_rdata_o <= output_mix_control_reg;
          FIR_MODE_ADDR: reg_rdata_o <= fir_output_mode_control_reg;
          HB_CTRL_ADDR: reg_rdata_o <= halfband_filter_control_reg | HB_FIXED_ONE; // [RQ19]
          OSC_CTRL_ADDR: reg_rdata_o <= oscillator_control_reg;
          OSC_FREQ0_ADDR: reg_rdata_o <= osc_freq_reg[7:0];
          OSC_FREQ1_ADDR: reg_rdata_o <= osc_freq_reg[15:8];
          OSC_FREQ2_ADDR: reg_rdata_o <= osc_freq_reg[23:16];
          OSC_FREQ3_ADDR: reg_rdata_o <= osc_freq_reg[31:24];
          OSC_PHASE0_ADDR: reg_rdata_o <= osc_phase_reg[7:0];
          OSC_PHASE1_ADDR: reg_rdata_o <= osc_phase_reg[15:8];
          default: reg_rdata_o <= 8'h00;
        endcase
      end
    end
  end

  // Target sync strobes, registered so each is a clean one-cycle pulse.
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      clkdiv_sync_o <= 1'b0;
      osc_sync_o <= 1'b0;
      halfband_sync_o <= 1'b0;
      mixer_sync_o <= 1'b0;
      monitor_sync_o <= 1'b0;
    end
    else
    begin
      clkdiv_sync_o <= pass_clkdiv; // [RQ7]
      osc_sync_o <= pass_osc; // [RQ5]
      halfband_sync_o <= pass_hb; // [RQ3]
      mixer_sync_o <= pass_mix; // [RQ9]
      monitor_sync_o <= pass_mon; // [RQ2]
    end
  end

  // Accumulator reloads on sync, steps while enabled and otherwise freezes,
  // so a disabled oscillator draws no switching power.
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      acc_reg <= '0;
    end
    else if (pass_osc)
    begin
      acc_reg <= {osc_phase_reg, 16'h0000}; // [RQ5]
    end
    else if (oscillator_control_reg[OC_ENABLE])
    begin
      acc_reg <= acc_reg + osc_freq_reg; // [RQ20]
    end
  end

  // Half-band decimation phase toggles each sample and restarts on sync.
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      hb_phase_reg <= 1'b0;
    end
    else if (pass_hb)
    begin
      hb_phase_reg <= halfband_filter_control_reg[HB_ALT_PHASE]; // [RQ3] [RQ16]
    end
    else
    begin
      hb_phase_reg <= !hb_phase_reg;
    end
  end

  // Mixer phase: eight steps per cycle, start state selects the quadrant.
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mix_phase_reg <= 3'h0;
    end
    else if (pass_mix)
    begin
      mix_phase_reg <= {output_mix_control_reg[MX_START_LO+:2], 1'b0}; // [RQ11]
    end
    else
    begin
      mix_phase_reg <= mix_phase_reg + 3'h1;
    end
  end

  // Sample stage: FIR gain, mixer sign and real/complex selection.
  always_comb
  begin
    stage_next = sample_i;
    if (fir_output_mode_control_reg[FM_FIR_EN] && !fir_output_mode_control_reg[FM_GAIN_ONE])
    begin
      stage_next.i = sample_i.i << 1; // [RQ12]
      stage_next.q = sample_i.q << 1; // [RQ12]
    end
    if (!fir_output_mode_control_reg[FM_MIX_OFF] && mix_phase_reg[2])
    begin
      stage_next.i = -stage_next.i; // [RQ13]
      stage_next.q = -stage_next.q;
    end
    if (!fir_output_mode_control_reg[FM_COMPLEX])
    begin
      stage_next.q = '0; // [RQ14]
    end
  end

  // The stage stalls when the FIFO is full, which stalls the sample source.
  assign stage_take = !stage_valid_reg || fifo_ready;
  assign sample_ready_o = stage_take;
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      stage_reg <= '0;
      stage_valid_reg <= 1'b0;
    end
    else if (stage_take)
    begin
      stage_valid_reg <= sample_valid_i;
      if (sample_valid_i)
      begin
        stage_reg <= stage_next;
      end
    end
  end

  sample_fifo #(
    .WIDTH(2 * SAMPLE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .in_data_i(stage_reg),
    .in_valid_i(stage_valid_reg),
    .in_ready_o(fifo_ready),
    .out_data_o(sample_o),
    .out_valid_o(sample_valid_o),
    .out_ready_i(sample_ready_i)
  );

  // Accumulator, phases and configuration levels to the filter, oscillator and mixer datapaths.
  assign phase_accumulator_32_o = acc_reg;
  assign osc_enable_o = oscillator_control_reg[OC_ENABLE]; // [RQ20]
  assign phase_dither_o = oscillator_control_reg[OC_PHASE_DITHER]; // [RQ21]
  assign amp_dither_o = oscillator_control_reg[OC_AMP_DITHER]; // [RQ21]
  assign halfband_phase_o = hb_phase_reg;
  assign halfband_highpass_o = halfband_filter_control_reg[HB_HIGHPASS]; // [RQ18]
  assign spectral_reverse_o = halfband_filter_control_reg[HB_REVERSE]; // [RQ17]
  assign fir_enable_o = fir_output_mode_control_reg[FM_FIR_EN]; // [RQ15]
  assign eighth_rate_mixer_phase_o = mix_phase_reg;

  // ============================================================
  // Assertions
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  a_master_gate: assert property (!master |=> !(clkdiv_sync_o || osc_sync_o ||
    halfband_sync_o || mixer_sync_o || monitor_sync_o)) // [RQ1]
    else $error("sync forwarded without master enable");
  a_monitor_pass: assert property (sync_edge && master && sync_gate_control_reg[SG_MON_EN]
    |=> monitor_sync_o) // [RQ2]
    else $error("monitor sync not forwarded");
  a_held_sync_once: assert property (sync_i && sync_prev_reg |=> !monitor_sync_o) // [RQ22]
    else $error("held sync counted twice");
  a_hb_restart: assert property (pass_hb |=> halfband_sync_o &&
    hb_phase_reg == $past(halfband_filter_control_reg[HB_ALT_PHASE])) // [RQ3]
    else $error("half-band not restarted at selected phase");
  a_hb_oneshot: assert property (pass_hb && sync_gate_control_reg[SG_HB_ONCE] && !wr_sync
    |=> !sync_gate_control_reg[SG_HB_EN] ##1 !halfband_sync_o) // [RQ4]
    else $error("half-band one-shot not cleared");
  a_osc_reload: assert property (pass_osc |=> // [RQ5]
    acc_reg == {$past(osc_phase_reg), 16'h0000})
    else $error("accumulator not reloaded");
  a_osc_oneshot: assert property (pass_osc && sync_gate_control_reg[SG_OSC_ONCE] && !wr_sync
    |=> !sync_gate_control_reg[SG_OSC_EN]) // [RQ6]
    else $error("oscillator one-shot not cleared");
  a_clkdiv_oneshot: assert property (pass_clkdiv && sync_gate_control_reg[SG_CLKDIV_ONCE]
    && !wr_sync |=> !sync_gate_control_reg[SG_CLKDIV_EN]) // [RQ8]
    else $error("divider one-shot not cleared");
  a_mix_oneshot: assert property (pass_mix && output_mix_control_reg[MX_ONCE] && !wr_mix
    |=> !output_mix_control_reg[MX_EN] && mixer_sync_o) // [RQ10]
    else $error("mixer one-shot not cleared");
  a_mix_start: assert property (pass_mix |=> mix_phase_reg ==
    {$past(output_mix_control_reg[MX_START_LO+:2]), 1'b0}) // [RQ11]
    else $error("mixer start phase wrong");
  a_write_wins: assert property (wr_sync |=> // [RQ23]
    sync_gate_control_reg == $past(reg_req_i.wdata))
    else $error("software write lost to self clear");
  a_reserved_one: assert property (reg_req_i.rd && reg_req_i.addr == HB_CTRL_ADDR
    |=> reg_rvalid_o && reg_rdata_o[0]) // [RQ19]
    else $error("reserved bit not read as one");

  c_oneshot_osc: cover property (pass_osc && sync_gate_control_reg[SG_OSC_ONCE]);
  c_all_targets: cover property (pass_hb && pass_osc && pass_clkdiv && pass_mix && pass_mon);
  c_fifo_full: cover property (stage_valid_reg && !fifo_ready);
endmodule

//--- logic/ddc_ctrl_pkg.sv
/*
  Shared constants and carrier types for the downconverter sync and filter control.
  Assumes one clock (the divided sample clock) and a byte-wide register port whose
  addresses are the printed register addresses.
*/
// Contract
// RQ1 - No sync reaches any target while the master sync enable is low.
// RQ2 - Monitor sync passes whenever its enable and master enable are high.
// RQ3 - Passed half-band sync restarts decimation at the selected phase.
// RQ4 - Half-band one-shot acts once, then its sync enable clears itself.
// RQ5 - Passed oscillator sync reloads the accumulator with the phase offset.
// RQ6 - Oscillator one-shot acts once, then its sync enable clears itself.
// RQ7 - Clock divider sync passes only with its enable and master enable high.
// RQ8 - Clock divider one-shot acts once, then its sync enable clears itself.
// RQ9 - Mixer sync passes only with its enable and master enable high.
// RQ10 - Mixer one-shot acts once, then the mixer sync enable clears itself.
// RQ11 - Mixer start phase comes from the two-bit start state field.
// RQ12 - Enabled FIR path has gain 1 with gain bit high, 2 when low.
// RQ13 - Mix disable bit bypasses the mixer; software sets it with complex mode.
// RQ14 - Complex output when complex mode bit is high, real otherwise.
// RQ15 - FIR runs when enabled; otherwise bypassed and held inactive.
// RQ16 - Decimation phase bit high selects the alternate half-band phase.
// RQ17 - Spectral reversal bit enables half-band spectral reversal.
// RQ18 - Select bit high gives high-pass half-band, low gives low-pass.
// RQ19 - Reserved bit 0 of the half-band control register reads one.
// RQ20 - Oscillator runs at programmed frequency when enabled, else bypassed.
// RQ21 - Phase and amplitude dither follow their enable bits.
// RQ22 - Sync input is edge detected; a held-high input is one event.
// RQ23 - One-shot clear lands with its sync; a same-cycle write wins.
package ddc_ctrl_pkg;
  localparam int ADDR_W = 13;
  localparam int SAMPLE_W = 16;
  localparam int FIFO_DEPTH = 8;
  // Register addresses.
  localparam logic [12:0] SYNC_GATE_ADDR = 13'h100;
  localparam logic [12:0] MIX_CTRL_ADDR = 13'h101;
  localparam logic [12:0] FIR_MODE_ADDR = 13'h102;
  localparam logic [12:0] HB_CTRL_ADDR = 13'h103;
  localparam logic [12:0] OSC_CTRL_ADDR = 13'h11d;
  localparam logic [12:0] OSC_FREQ0_ADDR = 13'h11e;
  localparam logic [12:0] OSC_FREQ1_ADDR = 13'h11f;
  localparam logic [12:0] OSC_FREQ2_ADDR = 13'h120;
  localparam logic [12:0] OSC_FREQ3_ADDR = 13'h121;
  localparam logic [12:0] OSC_PHASE0_ADDR = 13'h122;
  localparam logic [12:0] OSC_PHASE1_ADDR = 13'h123;
  // Sync gate control bits.
  localparam int SG_MASTER = 0;
  localparam int SG_CLKDIV_EN = 1;
  localparam int SG_CLKDIV_ONCE = 2;
  localparam int SG_OSC_EN = 3;
  localparam int SG_OSC_ONCE = 4;
  localparam int SG_HB_EN = 5;
  localparam int SG_HB_ONCE = 6;
  localparam int SG_MON_EN = 7;
  // Mixer control bits.
  localparam int MX_EN = 0;
  localparam int MX_ONCE = 1;
  localparam int MX_START_LO = 4;
  localparam logic [7:0] MX_WR_MASK = 8'h33;
  // FIR and output mode bits.
  localparam int FM_FIR_EN = 0;
  localparam int FM_COMPLEX = 1;
  localparam int FM_MIX_OFF = 2;
  localparam int FM_GAIN_ONE = 3;
  localparam logic [7:0] FM_WR_MASK = 8'h0f;
  // Half-band control bits; bit 0 is a constant one.
  localparam int HB_HIGHPASS = 1;
  localparam int HB_REVERSE = 2;
  localparam int HB_ALT_PHASE = 3;
  localparam logic [7:0] HB_WR_MASK = 8'h0e;
  localparam logic [7:0] HB_FIXED_ONE = 8'h01;
  // Oscillator control bits.
  localparam int OC_ENABLE = 0;
  localparam int OC_AMP_DITHER = 1;
  localparam int OC_PHASE_DITHER = 2;
  localparam logic [7:0] OC_WR_MASK = 8'h07;
  localparam logic [7:0] REG_RESET = 8'h00;
  typedef struct packed {
    logic [SAMPLE_W-1:0] i;
    logic [SAMPLE_W-1:0] q;
  } sample_s;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } reg_req_s;
endpackage

//--- testbench/ddc_far_side.sv
/*
  Far-side model: the external sync source and a sample sink that can stall.
  Assumes the control block's clock; everything changes on the falling edge.
*/
`timescale 1ns/1ps

// ============================================================
// Sync source and sample sink
module ddc_far_side (
  input wire logic clock_i,
  input wire logic stall_i,
  output logic sync_o,
  output logic sink_ready_o
);
  // The sink follows the stall request away from the sampling edge.
  initial
  begin
    sync_o = 1'b0;
    sink_ready_o = 1'b0;
    forever @(negedge clock_i) sink_ready_o = !stall_i;
  end

  // Held for three cycles, so a level must still count once.
  task automatic pulse();
    @(negedge clock_i);
    sync_o = 1'b1;
    repeat (3) @(negedge clock_i);
    sync_o = 1'b0;
    repeat (3) @(negedge clock_i);
  endtask
endmodule

//--- testbench/ddc_sync_and_filter_control_test.sv
/*
  Self-checking bench for the sync and filter control block.
  Assumes the far-side model drives sync and drains the sample FIFO.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end

// ============================================================
// Bench top
module ddc_sync_and_filter_control_test;
  import ddc_ctrl_pkg::*;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic stall = 1'b1;
  logic sync_i, sink_ready, sample_ready_o, sample_valid_o, reg_rvalid_o, sample_valid_i = 1'b0;
  logic clkdiv_sync_o, osc_sync_o, halfband_sync_o, mixer_sync_o, monitor_sync_o;
  logic osc_enable_o, phase_dither_o, amp_dither_o, halfband_phase_o;
  logic halfband_highpass_o, spectral_reverse_o, fir_enable_o, hb_seen;
  logic [2:0] eighth_rate_mixer_phase_o, mx_seen;
  logic [5:0] levels;
  logic [7:0] reg_rdata_o;
  logic [7:0] cnt [5];
  logic [31:0] phase_accumulator_32_o, acc;
  reg_req_s req = '0;
  sample_s sample_i = '0;
  sample_s sample_o;
  sample_s got [$];
  int comparisons = 0;
  int miscompares = 0;
  int n;
  bit ok;
  localparam logic [12:0] ADDRS [12] = '{SYNC_GATE_ADDR, MIX_CTRL_ADDR, FIR_MODE_ADDR,
    HB_CTRL_ADDR, OSC_CTRL_ADDR, OSC_FREQ0_ADDR, OSC_FREQ1_ADDR, OSC_FREQ2_ADDR,
    OSC_FREQ3_ADDR, OSC_PHASE0_ADDR, OSC_PHASE1_ADDR, 13'h104};
  localparam logic [7:0] MASKS [12] = '{8'hff, 8'h33, 8'h0f, 8'h0f, 8'h07, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'h00};

  always #10 clock_i = ~clock_i;

  // Configuration levels gathered into one word for a single comparison.
  assign levels = {fir_enable_o, halfband_highpass_o, spectral_reverse_o, osc_enable_o,
    phase_dither_o, amp_dither_o};

  ddc_far_side far (.clock_i(clock_i), .stall_i(stall), .sync_o(sync_i),
    .sink_ready_o(sink_ready));

  ddc_sync_control uut (.clock_i(clock_i), .rst_i(rst_i), .sync_i(sync_i), .reg_req_i(req),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .sample_i(sample_i),
    .sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o), .sample_o(sample_o),
    .sample_valid_o(sample_valid_o), .sample_ready_i(sink_ready),
    .clkdiv_sync_o(clkdiv_sync_o), .osc_sync_o(osc_sync_o), .halfband_sync_o(halfband_sync_o),
    .mixer_sync_o(mixer_sync_o), .monitor_sync_o(monitor_sync_o),
    .phase_accumulator_32_o(phase_accumulator_32_o), .osc_enable_o(osc_enable_o),
    .phase_dither_o(phase_dither_o), .amp_dither_o(amp_dither_o),
    .halfband_phase_o(halfband_phase_o), .halfband_highpass_o(halfband_highpass_o),
    .spectral_reverse_o(spectral_reverse_o), .fir_enable_o(fir_enable_o),
    .eighth_rate_mixer_phase_o(eighth_rate_mixer_phase_o));

  // Count target pulses and catch the phases that land with them.
  always @(posedge clock_i)
  begin
    if (clkdiv_sync_o === 1'b1) cnt[0]++;
    if (osc_sync_o === 1'b1) cnt[1]++;
    if (halfband_sync_o === 1'b1) hb_seen = halfband_phase_o;
    if (halfband_sync_o === 1'b1) cnt[2]++;
    if (mixer_sync_o === 1'b1) mx_seen = eighth_rate_mixer_phase_o;
    if (mixer_sync_o === 1'b1) cnt[3]++;
    if (monitor_sync_o === 1'b1) cnt[4]++;
    if (sample_valid_o === 1'b1 && sink_ready === 1'b1) got.push_back(sample_o);
  end

  task print_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(negedge clock_i);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge clock_i);
    req.wr = 1'b0;
  endtask

  // A read that never answers ends the run rather than hanging it.
  task automatic rd(input logic [12:0] a, input logic [7:0] e);
    int t;
    @(negedge clock_i);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge clock_i);
    req.rd = 1'b0;
    for (t = 0; t < 4 && reg_rvalid_o !== 1'b1; t++) @(negedge clock_i);
    if (t == 4)
    begin
      miscompares++;
      print_verdict();
    end
    `CHK("register read", e, reg_rdata_o)
  endtask

  // Fire k sync events and compare the pulses seen on each target.
  task automatic syncs(input int k, input logic [39:0] e);
    foreach (cnt[j]) cnt[j] = 8'h00;
    repeat (k) far.pulse();
    `CHK("sync counts", e, {cnt[0], cnt[1], cnt[2], cnt[3], cnt[4]})
  endtask

  task automatic push(input int k);
    @(negedge clock_i);
    ok = sample_ready_o;
    sample_valid_i = ok;
    sample_i.i = 16'h0100 + 16'(k);
    sample_i.q = 16'h0200 + 16'(k);
  endtask

  initial
  begin
    repeat (20) @(negedge clock_i);
    rst_i = 1'b0;
    foreach (ADDRS[j]) rd(ADDRS[j], (j == 3) ? 8'h01 : 8'h00);
    foreach (ADDRS[j]) wr(ADDRS[j], 8'hff);
    foreach (ADDRS[j]) rd(ADDRS[j], MASKS[j]);
    `CHK("levels on", 6'h3f, levels)
    foreach (ADDRS[j]) wr(ADDRS[j], 8'h00);
    `CHK("levels off", 6'h00, levels)
    $display("test registers done");
    wr(OSC_FREQ0_ADDR, 8'h05);
    wr(OSC_CTRL_ADDR, 8'h01);
    acc = phase_accumulator_32_o;
    repeat (4) @(negedge clock_i);
    `CHK("accumulator step", 32'd20, phase_accumulator_32_o - acc)
    wr(OSC_CTRL_ADDR, 8'h00);
    acc = phase_accumulator_32_o;
    repeat (3) @(negedge clock_i);
    `CHK("accumulator held", acc, phase_accumulator_32_o)
    $display("test oscillator done");
    wr(SYNC_GATE_ADDR, 8'hfe);
    wr(MIX_CTRL_ADDR, 8'h21);
    syncs(1, 40'h0);
    wr(SYNC_GATE_ADDR, 8'hab);
    wr(OSC_PHASE0_ADDR, 8'h34);
    wr(OSC_PHASE1_ADDR, 8'h12);
    wr(HB_CTRL_ADDR, 8'h08);
    syncs(2, 40'h0202020202);
    `CHK("accumulator load", 32'h12340000, phase_accumulator_32_o)
    `CHK("half-band phase", 1'b1, hb_seen)
    `CHK("mixer start", 3'b100, mx_seen)
    rd(SYNC_GATE_ADDR, 8'hab);
    wr(SYNC_GATE_ADDR, 8'h7f);
    wr(MIX_CTRL_ADDR, 8'h03);
    syncs(2, 40'h0101010100);
    rd(SYNC_GATE_ADDR, 8'h55);
    rd(MIX_CTRL_ADDR, 8'h02);
    $display("test sync done");
    // Fill against a stalled sink until refused, then drain and compare.
    wr(FIR_MODE_ADDR, 8'h07);
    n = 0;
    for (int k = 0; k < 20; k++)
    begin
      push(k);
      if (!ok) break;
      n++;
    end
    `CHK("accepted", FIFO_DEPTH + 1, n)
    stall = 1'b0;
    for (int t = 0; t < 60 && got.size() < n; t++) @(negedge clock_i);
    `CHK("drained", n, got.size())
    foreach (got[k])
      `CHK("word", {16'h0200 + 16'(2 * k), 16'h0400 + 16'(2 * k)}, got[k])
    `CHK("empty", 1'b0, sample_valid_o)
    got.delete();
    wr(FIR_MODE_ADDR, 8'h0c);
    push(5);
    @(negedge clock_i);
    sample_valid_i = 1'b0;
    for (int t = 0; t < 20 && got.size() < 1; t++) @(negedge clock_i);
    `CHK("real word", {16'h0105, 16'h0000}, got[0])
    // Eight back-to-back words with the mixer on: half of any eight steps are negated.
    got.delete();
    wr(FIR_MODE_ADDR, 8'h02);
    for (int k = 0; k < 8; k++) push(k);
    @(negedge clock_i);
    sample_valid_i = 1'b0;
    for (int t = 0; t < 30 && got.size() < 8; t++) @(negedge clock_i);
    n = 0;
    foreach (got[k]) if (got[k].i == 16'h0000 - 16'h0100 - 16'(k)) n++;
    `CHK("mixed words", 4, n)
    $display("test stream done");
    print_verdict();
  end
endmodule
